// ===== lock_ctrl.sv
// Lock-bit controller: timed lock reads and boot lock programming.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module lock_ctrl #(
  parameter logic [5:0] LOCK_INIT = lock_pkg::LOCK_ERASED,
  parameter int         PROG_LEN  = lock_pkg::PROG_CYCLES
) (
  input  wire logic       CLK,          // CPU clock, 50 MHz
  input  wire logic       SYS_RST,      // Synchronous reset, active high
  lock_link_if.dev        link,         // Core-side link
  input  wire logic       EE_BUSY,      // EEPROM write in progress
  input  wire logic [7:0] FLASH_RDATA,  // Flash byte at FLASH_ADDR
  output logic [15:0]     FLASH_ADDR,   // Flash read address
  output logic [5:0]      LOCK_BITS     // Current lock bits
);

  // ---------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------
  if (PROG_LEN < 1 || PROG_LEN > 65535) begin : g_bad_len
    $error("PROG_LEN out of range");
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  lock_pkg::lock_state_t state_q, state_d;
  logic        sel_q, sel_d;
  logic        en_q, en_d;
  logic [2:0]  win_q, win_d;
  logic [15:0] prog_cnt_q, prog_cnt_d;
  logic [5:0]  lock_q, lock_d;
  logic [5:0]  clear_q, clear_d;

  logic        rd_pend_q, rd_pend_d;
  logic        rd_lock_q, rd_lock_d;
  logic [15:0] faddr_q, faddr_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;

  logic        armed_both;
  logic        load_hit;
  logic        store_hit;
  logic [7:0]  lock_byte;

  // ---------------------------------------------------------------------
  // Window decode
  // ---------------------------------------------------------------------
  assign armed_both = (state_q == lock_pkg::ST_ARMED) && sel_q && en_q;

  // A lock read needs both bits and no EEPROM write.
  assign load_hit = armed_both && link.load_go && !EE_BUSY
                    && (win_q <= lock_pkg::WIN_LOAD);

  // The pointer takes no part in a lock write.
  assign store_hit = armed_both && link.store_go && !EE_BUSY
                     && (win_q <= lock_pkg::WIN_STORE);

  // Lock byte image returned to the load.
  always_comb begin
    lock_byte = {lock_pkg::LOCK_UNUSED, lock_q};
  end

  // ---------------------------------------------------------------------
  // Control bits, window and programming sequence
  // ---------------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    sel_d      = sel_q;
    en_d       = en_q;
    win_d      = win_q;
    prog_cnt_d = prog_cnt_q;
    lock_d     = lock_q;
    clear_d    = clear_q;
    unique case (state_q)
      lock_pkg::ST_IDLE: begin
        // The control register refuses writes while the EEPROM is
        // written, so no operation can be armed then.
        if (link.ctrl_wr && !EE_BUSY) begin
          sel_d = link.ctrl_wdata[lock_pkg::CTRL_SEL_POS];
          en_d  = link.ctrl_wdata[lock_pkg::CTRL_EN_POS];
          if (link.ctrl_wdata[lock_pkg::CTRL_SEL_POS] ||
              link.ctrl_wdata[lock_pkg::CTRL_EN_POS]) begin
            state_d = lock_pkg::ST_ARMED;
            win_d   = 3'h1;
          end
        end
      end
      lock_pkg::ST_ARMED: begin
        if (store_hit) begin
          // Boot lock bits (5:2) whose work-register bit is zero get programmed.
          clear_d    = 6'h00;
          clear_d[lock_pkg::BOOT_MSB:lock_pkg::BOOT_LSB] =
            ~link.work_data[lock_pkg::BOOT_MSB:lock_pkg::BOOT_LSB];
          prog_cnt_d = 16'(PROG_LEN - 1);
          state_d    = lock_pkg::ST_PROG;
        end else if (load_hit || win_q == lock_pkg::WIN_STORE) begin
          // Done with the read, or the window ran out.
          sel_d   = 1'b0;
          en_d    = 1'b0;
          win_d   = 3'h0;
          state_d = lock_pkg::ST_IDLE;
        end else begin
          win_d = win_q + 3'h1;
        end
      end
      lock_pkg::ST_PROG: begin
        if (prog_cnt_q == 16'h0000) begin
          lock_d  = lock_q & ~clear_q;
          clear_d = 6'h00;
          sel_d   = 1'b0;
          en_d    = 1'b0;
          win_d   = 3'h0;
          state_d = lock_pkg::ST_IDLE;
        end else begin
          prog_cnt_d = prog_cnt_q - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q    <= lock_pkg::ST_IDLE;
      sel_q      <= 1'b0;
      en_q       <= 1'b0;
      win_q      <= 3'h0;
      prog_cnt_q <= 16'h0000;
      lock_q     <= LOCK_INIT;
      clear_q    <= 6'h00;
    end else begin
      state_q    <= state_d;
      sel_q      <= sel_d;
      en_q       <= en_d;
      win_q      <= win_d;
      prog_cnt_q <= prog_cnt_d;
      lock_q     <= lock_d;
      clear_q    <= clear_d;
    end
  end

  // ---------------------------------------------------------------------
  // Load path
  // ---------------------------------------------------------------------
  // Loads are served every cycle, programming or not, so fetches and
  // loads never stall behind a lock write.
  always_comb begin
    rd_pend_d = 1'b0;
    rd_lock_d = 1'b0;
    faddr_d   = faddr_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    if (link.load_go) begin
      rd_pend_d = 1'b1;
      rd_lock_d = load_hit;
      faddr_d   = link.z_addr;
    end
    if (rd_pend_q) begin
      rvalid_d = 1'b1;
      // Out of the window a load is an ordinary flash read.
      rdata_d  = rd_lock_q ? lock_byte : FLASH_RDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_pend_q <= 1'b0;
      rd_lock_q <= 1'b0;
      faddr_q   <= 16'h0000;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
    end else begin
      rd_pend_q <= rd_pend_d;
      rd_lock_q <= rd_lock_d;
      faddr_q   <= faddr_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  logic [7:0] ctrl_view_q;
  logic       busy_q;
  logic [7:0] ctrl_view_d;

  always_comb begin
    ctrl_view_d = lock_pkg::CTRL_RESET;
    ctrl_view_d[lock_pkg::CTRL_SEL_POS] = sel_d;
    ctrl_view_d[lock_pkg::CTRL_EN_POS]  = en_d;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_view_q <= lock_pkg::CTRL_RESET;
      busy_q      <= 1'b0;
    end else begin
      ctrl_view_q <= ctrl_view_d;
      busy_q      <= (state_d == lock_pkg::ST_PROG);
    end
  end

  assign link.ctrl_rdata  = ctrl_view_q;
  assign link.load_rdata  = rdata_q;
  assign link.load_rvalid = rvalid_q;
  assign link.prog_busy   = busy_q;
  assign FLASH_ADDR       = faddr_q;
  assign LOCK_BITS        = lock_q;

endmodule

// ===== lock_pkg.sv
// Shared constants for the lock-bit self-access link.
package lock_pkg;

  // ---------------------------------------------------------------------
  // Store-program control register fields
  // ---------------------------------------------------------------------
  localparam int CTRL_EN_POS  = 0;
  localparam int CTRL_SEL_POS = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // Lock byte layout and values
  // ---------------------------------------------------------------------
  localparam int BOOT_LSB = 2;
  localparam int BOOT_MSB = 5;
  localparam int MEM_LSB  = 0;
  localparam int MEM_MSB  = 1;
  localparam logic [1:0]  LOCK_UNUSED   = 2'h3;
  localparam logic [5:0]  LOCK_ERASED   = 6'h3F;
  localparam logic [15:0] LOCK_READ_PTR = 16'h0001;

  // ---------------------------------------------------------------------
  // Timing windows in CPU cycles after the control write
  // ---------------------------------------------------------------------
  localparam logic [2:0] WIN_LOAD  = 3'h3;
  localparam logic [2:0] WIN_STORE = 3'h4;

  // ---------------------------------------------------------------------
  // Lock programming time
  // ---------------------------------------------------------------------
  localparam int PROG_TIME_US = 4;
  localparam int CLK_MHZ      = 50;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------------
  // Core-side register map on the Avalon-MM slave (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [4:0] ADR_CTRL   = 5'h00;
  localparam logic [4:0] ADR_PTR    = 5'h04;
  localparam logic [4:0] ADR_WORK   = 5'h08;
  localparam logic [4:0] ADR_ISSUE  = 5'h0C;
  localparam logic [4:0] ADR_RESULT = 5'h10;
  localparam logic [4:0] ADR_STATUS = 5'h14;
  localparam int ISSUE_STORE_POS = 0;
  localparam int ISSUE_LOAD_POS  = 1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARMED = 2'h1,
    ST_PROG  = 2'h3
  } lock_state_t;

endpackage

// ===== lock_link_if.sv
// Link between the processor core end and the lock-bit controller end.
`timescale 1ns/1ps
interface lock_link_if (
  input wire logic CLK        // Shared CPU clock
);
  logic        ctrl_wr;       // Control register write strobe
  logic [7:0]  ctrl_wdata;    // Control register write value
  logic [7:0]  ctrl_rdata;    // Control register contents
  logic        store_go;      // Store instruction strobe
  logic        load_go;       // Load instruction strobe
  logic [15:0] z_addr;        // Address pointer
  logic [7:0]  work_data;     // First work register value
  logic [7:0]  load_rdata;    // Load result byte
  logic        load_rvalid;   // Load result strobe
  logic        prog_busy;     // Lock programming in progress

  modport dev (
    input  ctrl_wr, ctrl_wdata, store_go, load_go, z_addr, work_data,
    output ctrl_rdata, load_rdata, load_rvalid, prog_busy
  );
  modport core (
    output ctrl_wr, ctrl_wdata, store_go, load_go, z_addr, work_data,
    input  ctrl_rdata, load_rdata, load_rvalid, prog_busy
  );
endinterface

// ===== core_port.sv
// Processor core end: Avalon-MM slave that issues link operations.
`timescale 1ns/1ps
module core_port (
  input  wire logic        CLK,              // CPU clock, 50 MHz
  input  wire logic        SYS_RST,          // Synchronous reset, high
  input  wire logic [4:0]  AVS_ADDRESS,      // Byte address
  input  wire logic        AVS_READ,         // Read request
  input  wire logic        AVS_WRITE,        // Write request
  input  wire logic [31:0] AVS_WRITEDATA,    // Write data
  output logic [31:0]      AVS_READDATA,     // Read data
  output logic             AVS_WAITREQUEST,  // Stall
  lock_link_if.core        link              // Controller link
);

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic        wait_q, wait_d;
  logic [31:0] rd_q, rd_d;
  logic [15:0] ptr_q, ptr_d;
  logic [7:0]  work_q, work_d;
  logic        cwr_q, cwr_d;
  logic [7:0]  cdat_q, cdat_d;
  logic        store_q, store_d;
  logic        load_q, load_d;
  logic [7:0]  res_q, res_d;
  logic        pend_q, pend_d;
  logic        req;
  logic        acc;

  assign req = AVS_READ || AVS_WRITE;
  // Every access stalls exactly one cycle, then completes.
  assign acc = req && !wait_q;

  always_comb begin
    wait_d = !(req && wait_q);
    rd_d   = rd_q;
    ptr_d  = ptr_q;
    work_d = work_q;
    cwr_d  = 1'b0;
    cdat_d = cdat_q;
    store_d = 1'b0;
    load_d  = 1'b0;
    res_d  = res_q;
    pend_d = pend_q;
    if (link.load_rvalid) begin
      res_d  = link.load_rdata;
      pend_d = 1'b0;
    end
    if (AVS_READ && wait_q) begin
      unique case (AVS_ADDRESS)
        lock_pkg::ADR_CTRL:   rd_d = {24'h000000, link.ctrl_rdata};
        lock_pkg::ADR_PTR:    rd_d = {16'h0000, ptr_q};
        lock_pkg::ADR_WORK:   rd_d = {24'h000000, work_q};
        lock_pkg::ADR_RESULT: rd_d = {24'h000000, res_q};
        lock_pkg::ADR_STATUS: rd_d = {30'h0000000, link.prog_busy, pend_q};
        default:              rd_d = 32'h00000000;
      endcase
    end
    if (acc && AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        lock_pkg::ADR_CTRL: begin
          // Software is expected to check EEPROM busy first.
          cwr_d  = 1'b1;
          cdat_d = AVS_WRITEDATA[7:0];
        end
        lock_pkg::ADR_PTR:  ptr_d  = AVS_WRITEDATA[15:0];
        lock_pkg::ADR_WORK: work_d = AVS_WRITEDATA[7:0];
        lock_pkg::ADR_ISSUE: begin
          store_d = AVS_WRITEDATA[lock_pkg::ISSUE_STORE_POS];
          load_d  = AVS_WRITEDATA[lock_pkg::ISSUE_LOAD_POS]
                    && !AVS_WRITEDATA[lock_pkg::ISSUE_STORE_POS];
          if (load_d) begin
            pend_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wait_q <= 1'b1;
      rd_q   <= 32'h00000000;
      ptr_q  <= lock_pkg::LOCK_READ_PTR;
      work_q <= 8'hFF;
      cwr_q  <= 1'b0;
      cdat_q <= lock_pkg::CTRL_RESET;
      store_q <= 1'b0;
      load_q  <= 1'b0;
      res_q  <= 8'h00;
      pend_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rd_q   <= rd_d;
      ptr_q  <= ptr_d;
      work_q <= work_d;
      cwr_q  <= cwr_d;
      cdat_q <= cdat_d;
      store_q <= store_d;
      load_q  <= load_d;
      res_q  <= res_d;
      pend_q <= pend_d;
    end
  end

  assign AVS_READDATA    = rd_q;
  assign AVS_WAITREQUEST = wait_q;
  assign link.ctrl_wr    = cwr_q;
  assign link.ctrl_wdata = cdat_q;
  assign link.store_go   = store_q;
  assign link.load_go    = load_q;
  assign link.z_addr     = ptr_q;
  assign link.work_data  = work_q;

endmodule

// ===== lock_link_asserts.sv
// Concurrent checks on the link between core end and lock controller.
`timescale 1ns/1ps
module lock_link_asserts #(
  parameter int PROG_LEN = 3
) (
  input wire logic        CLK,         // CPU clock
  input wire logic        SYS_RST,     // Synchronous reset, high
  input wire logic        ctrl_wr,     // Control write strobe
  input wire logic [7:0]  ctrl_wdata,  // Control write value
  input wire logic [7:0]  ctrl_rdata,  // Control register contents
  input wire logic        store_go,    // Store strobe
  input wire logic        load_go,     // Load strobe
  input wire logic [15:0] z_addr,      // Address pointer
  input wire logic [7:0]  work_data,   // Work register value
  input wire logic [7:0]  load_rdata,  // Load result byte
  input wire logic        load_rvalid, // Load result strobe
  input wire logic        prog_busy    // Lock programming running
);
  // -------------------------------------------------------------------
  // Helper counters
  // -------------------------------------------------------------------
  // Armed cycles are counted outside programming, as bits must lapse.
  // The count trails the controller's window count by one cycle.
  int         busy_len_q;
  int         busy_len_d;
  logic [3:0] arm_len_q;
  logic [3:0] arm_len_d;

  always_comb begin
    busy_len_d = prog_busy ? busy_len_q + 1 : 0;
    arm_len_d  = (ctrl_rdata != 8'h00 && !prog_busy) ? arm_len_q + 4'h1
                                                     : 4'h0;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      busy_len_q <= 0;
      arm_len_q  <= 4'h0;
    end else begin
      busy_len_q <= busy_len_d;
      arm_len_q  <= arm_len_d;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_load_answer_lag: assert property (load_go |-> ##2 load_rvalid)
    else $error("load answer not two cycles after load");
  a_answer_has_cause: assert property (
    load_rvalid |-> $past(load_go, 2))
    else $error("load answer without a load");
  a_lock_byte_top: assert property (
    load_rvalid && $past(load_go, 2) && $past(ctrl_rdata, 2) == 8'h09
    && !$past(prog_busy, 2) && $past(arm_len_q, 2) <= 4'h2
    |-> load_rdata[7:6] == 2'b11)
    else $error("unused lock byte bits not high");
  a_read_clears_bits: assert property (
    load_go && ctrl_rdata == 8'h09 && !prog_busy |-> ##2 ctrl_rdata == 8'h00)
    else $error("control bits not cleared after load");
  a_window_bound: assert property (arm_len_q <= 4'h4)
    else $error("control bits outlive the window");
  a_store_starts: assert property (
    store_go && ctrl_rdata == 8'h09 && !prog_busy |=> prog_busy)
    else $error("armed store did not start programming");
  a_arm_needs_write: assert property (
    ctrl_rdata != 8'h00 && $past(ctrl_rdata) == 8'h00
    |-> $past(ctrl_wr) && ctrl_rdata == ($past(ctrl_wdata) & 8'h09))
    else $error("control bits set without a control write");
  a_prog_length: assert property (
    $fell(prog_busy) |-> busy_len_q == PROG_LEN)
    else $error("programming length wrong");
  a_prog_end_clears: assert property (
    $fell(prog_busy) |-> ##[0:1] ctrl_rdata == 8'h00)
    else $error("control bits not cleared after programming");
  a_no_fetch_stall: assert property (
    prog_busy && load_go |-> ##1 !load_rvalid ##1 load_rvalid)
    else $error("load stalled during programming");
endmodule

// ===== tb.sv
// Self-checking bench for the core port and lock controller pair.
`timescale 1ns/1ps
module tb;
  localparam int PLEN = 20;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        waitreq;
  logic        ee = 1'b0;
  logic [7:0]  fdat = 8'h5A;
  logic [15:0] faddr;
  logic [5:0]  lock;
  logic [5:0]  exp_lock = lock_pkg::LOCK_ERASED;
  logic [31:0] got;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #10 clk = ~clk;

  lock_link_if link_if (.CLK(clk));
  core_port core_port_inst (.CLK(clk), .SYS_RST(sys_rst),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq), .link(link_if.core));
  lock_ctrl #(.PROG_LEN(PLEN)) lock_ctrl_inst (.CLK(clk), .SYS_RST(sys_rst),
    .link(link_if.dev), .EE_BUSY(ee), .FLASH_RDATA(fdat),
    .FLASH_ADDR(faddr), .LOCK_BITS(lock));
  lock_link_asserts #(.PROG_LEN(PLEN)) lock_link_asserts_inst (.CLK(clk),
    .SYS_RST(sys_rst), .ctrl_wr(link_if.ctrl_wr),
    .ctrl_wdata(link_if.ctrl_wdata), .ctrl_rdata(link_if.ctrl_rdata),
    .store_go(link_if.store_go), .load_go(link_if.load_go),
    .z_addr(link_if.z_addr), .work_data(link_if.work_data),
    .load_rdata(link_if.load_rdata), .load_rvalid(link_if.load_rvalid),
    .prog_busy(link_if.prog_busy));

  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask

  // Entered at a rising edge; the request stays up so the caller can chain
  // the next transfer at the accept edge without a gap, or call rel.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    got = rdat;
    if (n == 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  task automatic rel;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic poll(input int b);
    int n;
    for (n = 0; n < 30; n++) begin
      bus(1'b0, lock_pkg::ADR_STATUS, 32'h0);
      if (got[b] === 1'b0) break;
    end
    if (n == 30) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic lock_read;
    bus(1'b1, lock_pkg::ADR_PTR, 32'h1);
    bus(1'b1, lock_pkg::ADR_CTRL, 32'h9);
    bus(1'b1, lock_pkg::ADR_ISSUE, 32'h2);
    poll(0);
    bus(1'b0, lock_pkg::ADR_RESULT, 32'h0);
    chk(got, {24'h0, lock_pkg::LOCK_UNUSED, exp_lock});
    bus(1'b0, lock_pkg::ADR_CTRL, 32'h0);
    chk(got, 32'h0);
    rel();
  endtask

  task automatic lock_store;
    bus(1'b1, lock_pkg::ADR_WORK, 32'hD7);
    bus(1'b1, lock_pkg::ADR_PTR, 32'h1234);
    bus(1'b1, lock_pkg::ADR_CTRL, 32'h9);
    bus(1'b1, lock_pkg::ADR_ISSUE, 32'h1);
    exp_lock = exp_lock & {4'h5, 2'h3};
    bus(1'b1, lock_pkg::ADR_ISSUE, 32'h2);
    poll(0);
    bus(1'b0, lock_pkg::ADR_RESULT, 32'h0);
    chk(got, 32'h5A);
    chk({16'h0, faddr}, 32'h1234);
    bus(1'b0, lock_pkg::ADR_STATUS, 32'h0);
    chk(got, 32'h2);
    poll(1);
    rel();
    chk({26'h0, lock}, {26'h0, exp_lock});
  endtask

  task automatic ee_block;
    ee <= 1'b1;
    bus(1'b1, lock_pkg::ADR_CTRL, 32'h9);
    bus(1'b0, lock_pkg::ADR_CTRL, 32'h0);
    chk(got, 32'h0);
    bus(1'b1, lock_pkg::ADR_ISSUE, 32'h2);
    poll(0);
    bus(1'b0, lock_pkg::ADR_RESULT, 32'h0);
    chk(got, 32'h5A);
    bus(1'b1, lock_pkg::ADR_CTRL, 32'h9);
    bus(1'b1, lock_pkg::ADR_ISSUE, 32'h1);
    rel();
    bus(1'b0, lock_pkg::ADR_STATUS, 32'h0);
    chk(got, 32'h0);
    rel();
    ee <= 1'b0;
    chk({26'h0, lock}, {26'h0, exp_lock});
  endtask

  task automatic window_lapse;
    bus(1'b1, lock_pkg::ADR_CTRL, 32'h9);
    rel();
    repeat (6) @(posedge clk);
    bus(1'b0, lock_pkg::ADR_CTRL, 32'h0);
    chk(got, 32'h0);
    bus(1'b1, lock_pkg::ADR_ISSUE, 32'h2);
    poll(0);
    bus(1'b0, lock_pkg::ADR_RESULT, 32'h0);
    chk(got, 32'h5A);
    bus(1'b0, 5'h18, 32'h0);
    chk(got, 32'h0);
    rel();
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({26'h0, lock}, {26'h0, exp_lock});
    lock_read();
    lock_store();
    lock_read();
    ee_block();
    window_lapse();
    wrap_up();
  end
endmodule
